// [hdl/fcr_delay_timer.sv]
// on-delay / off-delay qualifier counted in prescaler ticks
`timescale 1ns/10ps
module fcr_delay_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic tick,
  input wire logic set_cond,
  input wire logic rel_cond,
  input wire logic [15:0] on_ticks,
  input wire logic [15:0] off_ticks,
  output logic active
);
  fcr_pkg::fcr_tmr_t s_r; // registered state
  fcr_pkg::fcr_tmr_t s_nxt; // next state
  logic on_due; // on delay surely elapsed
  logic off_due; // off delay surely elapsed

  // ----------------------------------------------------------------
  // qualify
  // ----------------------------------------------------------------
  // the tick phase is free running, so the first tick may land
  // right after the condition starts; one extra tick makes sure
  // the whole delay has passed; the top setting cannot exceed the
  // counter and so loses that one tick
  assign on_due = (on_ticks == 16'h0000) || (s_r.cnt > on_ticks) ||
                  (s_r.cnt == 16'hFFFF);
  assign off_due = (off_ticks == 16'h0000) || (s_r.cnt > off_ticks) ||
                   (s_r.cnt == 16'hFFFF);

  // any gap in the condition restarts the count, so only a
  // continuous stretch qualifies; resolution is one tick
  always_comb begin
    s_nxt = s_r;
    unique case (s_r.st)
      fcr_pkg::FCR_TMR_OFF: begin
        if (!set_cond) begin
          s_nxt.cnt = 16'h0000;
        end else if (on_due) begin
          s_nxt.st = fcr_pkg::FCR_TMR_ON;
          s_nxt.cnt = 16'h0000;
        end else if (tick) begin
          s_nxt.cnt = s_r.cnt + 16'h0001;
        end
      end
      fcr_pkg::FCR_TMR_ON: begin
        if (!rel_cond) begin
          s_nxt.cnt = 16'h0000;
        end else if (off_due) begin
          s_nxt.st = fcr_pkg::FCR_TMR_OFF;
          s_nxt.cnt = 16'h0000;
        end else if (tick) begin
          s_nxt.cnt = s_r.cnt + 16'h0001;
        end
      end
    endcase
  end

  // state register, frozen while ce is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign active = (s_r.st == fcr_pkg::FCR_TMR_ON);

  chk_tmr_soon: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && !active && s_r.cnt < on_ticks) |=> !active)
    else $error("relay asserted before on delay");
  chk_tmr_keep: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && active && !rel_cond) |=> active)
    else $error("relay released without release condition");
  chk_tmr_off: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && active && s_r.cnt < off_ticks) |=> active)
    else $error("relay released before off delay");
endmodule

// [hdl/fcr_freq_hyst.sv]
// frequency detection with hysteresis band
`timescale 1ns/10ps
module fcr_freq_hyst (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [15:0] freq,
  input wire logic [15:0] lvl,
  input wire logic [7:0] wid,
  output logic det
);
  fcr_pkg::fcr_hyst_t s_r; // registered state
  fcr_pkg::fcr_hyst_t s_nxt; // next state
  logic [16:0] upper; // level plus width
  logic above; // strictly over upper bound
  logic below; // strictly under level

  // ----------------------------------------------------------------
  // band compare
  // ----------------------------------------------------------------
  // one bit wider so a high level plus width cannot wrap
  always_comb begin
    upper = {1'b0, lvl} + {9'h000, wid};
    above = {1'b0, freq} > upper;
    below = freq < lvl;
    s_nxt = s_r;
    if (above) begin
      s_nxt.det = 1'b1;
    end else if (below) begin
      s_nxt.det = 1'b0;
    end
  end

  // state register, frozen while ce is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign det = s_r.det;

  chk_hyst_on: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && above) |=> det)
    else $error("detection one not set above band");
  chk_hyst_clr: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && below) |=> !det)
    else $error("detection one not cleared below level");
  chk_in_band: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && !above && !below) |=> $stable(det))
    else $error("detection changed inside band");
endmodule

// [hdl/fcr_map.svh]
// register offsets, field positions, reset values and timing counts
`ifndef FCR_MAP_SVH
`define FCR_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define FCR_OFS_SEL 8'h00
`define FCR_OFS_FLVL 8'h04
`define FCR_OFS_FWID 8'h08
`define FCR_OFS_CLVL 8'h0C
`define FCR_OFS_CDLY 8'h10
`define FCR_OFS_CLV2 8'h14
`define FCR_OFS_LLVL 8'h18
`define FCR_OFS_LDLY 8'h1C
`define FCR_OFS_STAT 8'h20
`define FCR_OFS_ISTA 8'h24
`define FCR_OFS_IMSK 8'h28

// ----------------------------------------------------------------
// relay function codes and field layout
// ----------------------------------------------------------------
`define FCR_FN_DET1 8'h04
`define FCR_FN_DET2 8'h05
`define FCR_FN_CAGR 8'h0D
`define FCR_FN_LOWC 8'h39
`define FCR_EV_DET1 0
`define FCR_EV_DET2 1
`define FCR_EV_CAGR 2
`define FCR_EV_LOWC 3
`define FCR_STAT_RELAY 4

// ----------------------------------------------------------------
// reset values and setting limits
// ----------------------------------------------------------------
`define FCR_RST_FWID 8'h01
`define FCR_RST_CDLY 7'h01
`define FCR_FWID_MIN 8'h01
`define FCR_CDLY_MIN 7'h01
`define FCR_CDLY_MAX 7'h64
`define FCR_CLVL_MIN 16'h0001
`define FCR_LVL_MAX 16'h270F
`define FCR_FLVL_MAX 16'h2EE0
`define FCR_RESP_OKAY 2'b00
`define FCR_RESP_SLVERR 2'b10

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FCR_CLK_NS 4
`define FCR_TICK_MS 10
`define FCR_TICK_CYC ((`FCR_TICK_MS * 1000000) / `FCR_CLK_NS)
`define FCR_REL_MS 100
`define FCR_REL_TICKS 16'(`FCR_REL_MS / `FCR_TICK_MS)
`define FCR_CDLY_UNIT 16'h000A

`endif

// [hdl/fcr_pkg.sv]
// state types of the frequency and current detection block
package fcr_pkg;

  // ----------------------------------------------------------------
  // delay timer
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    FCR_TMR_OFF = 1'b0,
    FCR_TMR_ON = 1'b1
  } fcr_tmr_st_t;

  typedef struct packed {
    fcr_tmr_st_t st; // output state
    logic [15:0] cnt; // elapsed ticks
  } fcr_tmr_t;

  // ----------------------------------------------------------------
  // frequency hysteresis
  // ----------------------------------------------------------------
  typedef struct packed {
    logic det; // detection one
  } fcr_hyst_t;

  // ----------------------------------------------------------------
  // top level: settings, irq, bus slave
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0][7:0] sel; // relay function codes
    logic [15:0] flvl; // freq level, 0.1 hz
    logic [7:0] fwid; // freq width, 0.1 hz
    logic [15:0] clvl; // current agree level, 0.1 a
    logic [6:0] cdly; // current agree delay, 0.1 s
    logic [15:0] clv2; // release level, 0.1 a
    logic [15:0] llvl; // low current level, 0.1 a
    logic [15:0] ldly; // low current delay, 10 ms
    logic [3:0] ista; // sticky events
    logic [3:0] imsk; // irq enables
    logic [3:0] evp; // previous source levels
    logic [2:0] relay; // relay drive
    logic [21:0] pre; // tick prescaler
    logic tick; // 10 ms pulse
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } fcr_state_t;

endpackage

// [hdl/fcr_relay_detect.sv]
// level detection relays with axi4-lite settings and interrupt
`timescale 1ns/10ps
`include "fcr_map.svh"

module fcr_relay_detect #(
  parameter int TICK_CYCLES = `FCR_TICK_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [15:0] out_freq,
  input wire logic [15:0] out_current,
  output logic [2:0] relay_out,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam logic [21:0] PRE_LAST = 22'(TICK_CYCLES - 1);

  fcr_pkg::fcr_state_t s_r; // registered state
  fcr_pkg::fcr_state_t s_nxt; // next state
  logic det1; // frequency detection one
  logic det2; // frequency detection two
  logic cagr; // qualified current agree
  logic lowc; // qualified low current
  logic cagr_set; // current over agree level
  logic cagr_rel; // current at or under level two
  logic lowc_set; // current under low level, enabled
  logic [15:0] cagr_on; // agree delay in ticks
  logic [2:0] relay_d; // per relay selected source
  logic [3:0] src; // event sources
  logic aw_take; // write address handshake
  logic w_take; // write data handshake
  logic ar_take; // read address handshake
  logic aw_h; // address held or arriving
  logic w_h; // data held or arriving
  logic [7:0] wa; // effective write address
  logic [31:0] wd; // effective write data
  logic [3:0] ws; // effective write strobes
  logic [31:0] wv; // merged write value
  logic [3:0] w1c; // sticky bits to clear

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // register read mux, shared by reads and byte-lane merging
  function automatic logic [31:0] rd_reg(input logic [7:0] a,
      input fcr_pkg::fcr_state_t st, input logic [3:0] live);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      `FCR_OFS_SEL: r = {8'h00, st.sel};
      `FCR_OFS_FLVL: r = {16'h0000, st.flvl};
      `FCR_OFS_FWID: r = {24'h00_0000, st.fwid};
      `FCR_OFS_CLVL: r = {16'h0000, st.clvl};
      `FCR_OFS_CDLY: r = {25'h000_0000, st.cdly};
      `FCR_OFS_CLV2: r = {16'h0000, st.clv2};
      `FCR_OFS_LLVL: r = {16'h0000, st.llvl};
      `FCR_OFS_LDLY: r = {16'h0000, st.ldly};
      `FCR_OFS_STAT: r = {25'h000_0000, st.relay, live};
      `FCR_OFS_ISTA: r = {28'h000_0000, st.ista};
      `FCR_OFS_IMSK: r = {28'h000_0000, st.imsk};
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // unmapped offsets answer slverr
  function automatic logic mapped(input logic [7:0] a);
    logic m;
    m = (a <= `FCR_OFS_IMSK) && (a[1:0] == 2'b00);
    return m;
  endfunction

  // keep old bytes where the strobe is low
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // ----------------------------------------------------------------
  // detectors
  // ----------------------------------------------------------------
  fcr_freq_hyst u_hyst (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .freq(out_freq),
    .lvl(s_r.flvl),
    .wid(s_r.fwid),
    .det(det1)
  );

  // complement of a held state keeps the same hold inside the band
  assign det2 = ~det1;

  // agree: set over level, release at or under level two
  assign cagr_set = out_current > s_r.clvl;
  assign cagr_rel = out_current <= s_r.clv2;
  assign cagr_on = {9'h000, s_r.cdly} * `FCR_CDLY_UNIT;

  fcr_delay_timer u_cagr (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .tick(s_r.tick),
    .set_cond(cagr_set),
    .rel_cond(cagr_rel),
    .on_ticks(cagr_on),
    .off_ticks(`FCR_REL_TICKS),
    .active(cagr)
  );

  // a zero level switches low current detection off
  assign lowc_set = (s_r.llvl != 16'h0000) &&
                    (out_current < s_r.llvl);

  fcr_delay_timer u_lowc (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .tick(s_r.tick),
    .set_cond(lowc_set),
    .rel_cond(!lowc_set),
    .on_ticks(s_r.ldly),
    .off_ticks(`FCR_REL_TICKS),
    .active(lowc)
  );

  assign src = {lowc, cagr, det2, det1};

  // ----------------------------------------------------------------
  // relay routing
  // ----------------------------------------------------------------
  // unsupported codes leave the relay released
  for (genvar g = 0; g < 3; g++) begin : g_relay
    always_comb begin
      case (s_r.sel[g])
        `FCR_FN_DET1: relay_d[g] = det1;
        `FCR_FN_DET2: relay_d[g] = det2;
        `FCR_FN_CAGR: relay_d[g] = cagr;
        `FCR_FN_LOWC: relay_d[g] = lowc;
        default: relay_d[g] = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // bus handshakes
  // ----------------------------------------------------------------
  // readies and valids are gated by ce, which must freeze the
  // master too, so no beat is taken while state stands still
  assign s_axi_awready = ce && !s_r.aw_got && !s_r.bvalid;
  assign s_axi_wready = ce && !s_r.w_got && !s_r.bvalid;
  assign s_axi_arready = ce && !s_r.rvalid;
  assign s_axi_bvalid = ce && s_r.bvalid;
  assign s_axi_rvalid = ce && s_r.rvalid;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign aw_h = s_r.aw_got || aw_take;
  assign w_h = s_r.w_got || w_take;
  assign wa = s_r.aw_got ? s_r.awaddr : s_axi_awaddr;
  assign wd = s_r.w_got ? s_r.wdata : s_axi_wdata;
  assign ws = s_r.w_got ? s_r.wstrb : s_axi_wstrb;
  assign wv = merge(rd_reg(wa, s_r, src), wd, ws);
  assign w1c = wd[3:0] & {4{ws[0]}};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    // prescaler for the 10 ms timer tick
    s_nxt.tick = (s_r.pre == PRE_LAST);
    s_nxt.pre = s_nxt.tick ? 22'h00_0000 : s_r.pre + 22'h00_0001;
    s_nxt.relay = relay_d;
    // hold whichever write half arrives first
    if (aw_take && !w_h) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (w_take && !aw_h) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    // both halves present: write and answer
    if (aw_h && w_h) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = mapped(wa) ? `FCR_RESP_OKAY : `FCR_RESP_SLVERR;
      case (wa)
        `FCR_OFS_SEL: s_nxt.sel = wv[23:0];
        `FCR_OFS_FLVL: begin
          s_nxt.flvl = (wv[15:0] > `FCR_FLVL_MAX) ? `FCR_FLVL_MAX :
                       wv[15:0];
        end
        `FCR_OFS_FWID: begin
          s_nxt.fwid = (wv[7:0] < `FCR_FWID_MIN) ? `FCR_FWID_MIN :
                       wv[7:0];
        end
        `FCR_OFS_CLVL: begin
          if (wv[15:0] < `FCR_CLVL_MIN) begin
            s_nxt.clvl = `FCR_CLVL_MIN;
          end else if (wv[15:0] > `FCR_LVL_MAX) begin
            s_nxt.clvl = `FCR_LVL_MAX;
          end else begin
            s_nxt.clvl = wv[15:0];
          end
          // lowering the agree level drags level two down
          if (s_r.clv2 > s_nxt.clvl) begin
            s_nxt.clv2 = s_nxt.clvl;
          end
        end
        `FCR_OFS_CDLY: begin
          if (wv > {25'h000_0000, `FCR_CDLY_MAX}) begin
            s_nxt.cdly = `FCR_CDLY_MAX;
          end else if (wv[6:0] < `FCR_CDLY_MIN) begin
            s_nxt.cdly = `FCR_CDLY_MIN;
          end else begin
            s_nxt.cdly = wv[6:0];
          end
        end
        `FCR_OFS_CLV2: begin
          s_nxt.clv2 = (wv[15:0] > s_r.clvl) ? s_r.clvl :
                       wv[15:0];
        end
        `FCR_OFS_LLVL: begin
          s_nxt.llvl = (wv[15:0] > `FCR_LVL_MAX) ? `FCR_LVL_MAX :
                       wv[15:0];
        end
        `FCR_OFS_LDLY: s_nxt.ldly = wv[15:0];
        `FCR_OFS_ISTA: s_nxt.ista = s_r.ista & ~w1c;
        `FCR_OFS_IMSK: s_nxt.imsk = wv[3:0];
        default: s_nxt.ista = s_nxt.ista;
      endcase
    end
    // rising source edges; applied after the clear so set wins
    s_nxt.evp = src;
    s_nxt.ista = s_nxt.ista | (src & ~s_r.evp);
    // read channel
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (ar_take) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rd_reg(s_axi_araddr, s_r, src);
      s_nxt.rresp = mapped(s_axi_araddr) ? `FCR_RESP_OKAY :
                    `FCR_RESP_SLVERR;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.fwid <= `FCR_RST_FWID;
      s_r.cdly <= `FCR_RST_CDLY;
      // detection two idles high, so no false edge after reset
      s_r.evp[`FCR_EV_DET2] <= 1'b1;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign relay_out = s_r.relay;
  assign irq = |(s_r.ista & s_r.imsk);
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_sel_one: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && s_r.sel[0] == `FCR_FN_DET1) |=> relay_out[0] == $past(det1))
    else $error("relay zero does not follow detection one");
  chk_sel_agr: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && s_r.sel[1] == `FCR_FN_CAGR) |=> relay_out[1] == $past(cagr))
    else $error("relay one does not follow current agree");
  chk_sel_low: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && s_r.sel[2] == `FCR_FN_LOWC) |=> relay_out[2] == $past(lowc))
    else $error("relay two does not follow low current");
  chk_lvl2_cap: assert property (@(posedge aclk) disable iff (!aresetn)
    s_r.clv2 <= s_r.clvl)
    else $error("level two above agree level");
  chk_cdly_rng: assert property (@(posedge aclk) disable iff (!aresetn)
    s_r.cdly >= `FCR_CDLY_MIN && s_r.cdly <= `FCR_CDLY_MAX)
    else $error("agree delay out of range");
  chk_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && det1 && !$past(det1) && s_r.imsk[0]) |=> irq)
    else $error("unmasked event did not raise irq");
endmodule

// [verification/fcr_relay_contacts.sv]
// relay contact model standing on the far side of the relay drive
`timescale 1ns/10ps
module fcr_relay_contacts (
  input wire logic aclk,
  input wire logic [2:0] relay_out,
  output logic [2:0] closed
);
  // contacts follow the coils one cycle late; bounce not modelled
  always_ff @(posedge aclk) begin
    closed <= relay_out;
  end
endmodule

// [verification/testbench.sv]
// self-checking bench of the detection relay block
`timescale 1ns/10ps
`include "fcr_map.svh"
module testbench;
  logic aclk = 0;
  logic aresetn = 0;
  logic ce = 1'b1; // block enabled except for the ce freeze check near the end
  logic [15:0] out_freq = 16'h0000;
  logic [15:0] out_current = 16'h0000;
  logic [2:0] relay_out;
  logic [2:0] closed; // contact state seen by the far side
  logic irq;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [31:0] s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF; // whole words only
  logic s_axi_awvalid = 0;
  logic s_axi_wvalid = 0;
  logic s_axi_arvalid = 0;
  // responses always accepted, so no gap is needed between calls
  logic s_axi_bready = 1'b1;
  logic s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;

  // short tick keeps the delays at tens of cycles
  fcr_relay_detect #(.TICK_CYCLES(10)) u_fcr_relay_detect (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .out_freq(out_freq),
    .out_current(out_current), .relay_out(relay_out), .irq(irq),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

  fcr_relay_contacts u_fcr_relay_contacts (
    .aclk(aclk), .relay_out(relay_out), .closed(closed));

  // ----------------------------------------------------------------
  // clock, timeout and verdict
  // ----------------------------------------------------------------
  always #2 aclk = ~aclk;

  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // run needs under 1000 cycles; ceiling well above
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // compare and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ready is looked at on the falling edge, stable until the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic aw;
    logic w;
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(negedge aclk);
      aw = aw | s_axi_awready;
      w = w | s_axi_wready;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    chk(32'(s_axi_bresp), 32'(er));
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    logic ar;
    ar = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!ar) begin
      @(negedge aclk);
      ar = s_axi_arready;
      @(posedge aclk);
    end
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata, ed);
    chk(32'(s_axi_rresp), 32'(er));
    @(posedge aclk);
  endtask

  // relay i must reach v no sooner than lo and before hi cycles
  task automatic settle(input int i, input logic v, input int lo,
                        input int hi);
    int n;
    n = 0;
    while (relay_out[i] !== v && n < hi) begin
      @(negedge aclk);
      n++;
    end
    chk(32'(n >= lo && n < hi), 32'h0000_0001);
    @(posedge aclk);
  endtask

  // all relays must sit at e after c cycles
  task automatic stay(input int c, input logic [2:0] e);
    repeat (c) @(negedge aclk);
    chk(32'(relay_out), 32'(e));
    chk(32'(closed), 32'(e));
    @(posedge aclk);
  endtask

  // irq is a registered level: look at it away from the clock edge
  task automatic chk_irq(input logic e);
    @(negedge aclk);
    chk(32'(irq), 32'(e));
    @(posedge aclk);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`FCR_OFS_CDLY, 32'h0000_0001, `FCR_RESP_OKAY);
    rd(8'h2C, 32'h0000_0000, `FCR_RESP_SLVERR);
    wr(`FCR_OFS_CDLY, 32'h0000_0000, `FCR_RESP_OKAY);
    rd(`FCR_OFS_CDLY, 32'h0000_0001, `FCR_RESP_OKAY);
    wr(`FCR_OFS_CDLY, 32'h0000_00C8, `FCR_RESP_OKAY);
    rd(`FCR_OFS_CDLY, 32'h0000_0064, `FCR_RESP_OKAY);
    wr(`FCR_OFS_CDLY, 32'h0000_0001, `FCR_RESP_OKAY);
    // relay0 detection one, relay1 detection two, relay2 current agree
    wr(`FCR_OFS_SEL, 32'h000D_0504, `FCR_RESP_OKAY);
    wr(`FCR_OFS_FLVL, 32'h0000_0064, `FCR_RESP_OKAY);
    wr(`FCR_OFS_FWID, 32'h0000_000A, `FCR_RESP_OKAY);
    wr(`FCR_OFS_ISTA, 32'h0000_000F, `FCR_RESP_OKAY);
    out_freq <= 16'h006E; // exactly level plus width: no set yet
    stay(10, 3'b010);
    out_freq <= 16'h006F;
    settle(0, 1'b1, 0, 5);
    stay(2, 3'b001);
    // live detections in the low nibble, relay drive above
    rd(`FCR_OFS_STAT, 32'h0000_0011, `FCR_RESP_OKAY);
    chk_irq(1'b0);
    rd(`FCR_OFS_ISTA, 32'h0000_0001, `FCR_RESP_OKAY);
    wr(`FCR_OFS_IMSK, 32'h0000_0001, `FCR_RESP_OKAY);
    chk_irq(1'b1);
    wr(`FCR_OFS_ISTA, 32'h0000_0001, `FCR_RESP_OKAY);
    chk_irq(1'b0);
    out_freq <= 16'h0064; // at the level: inside band, held
    stay(10, 3'b001);
    out_freq <= 16'h0063;
    settle(0, 1'b0, 0, 5);
    stay(2, 3'b010);
    // release level is clamped to the agree level
    wr(`FCR_OFS_CLVL, 32'h0000_00C8, `FCR_RESP_OKAY);
    wr(`FCR_OFS_CLV2, 32'h0000_012C, `FCR_RESP_OKAY);
    rd(`FCR_OFS_CLV2, 32'h0000_00C8, `FCR_RESP_OKAY);
    wr(`FCR_OFS_CLV2, 32'h0000_0096, `FCR_RESP_OKAY);
    out_current <= 16'h00FA; // 0.1 s agree delay is 100 cycles
    settle(2, 1'b1, 95, 130);
    out_current <= 16'h00B4; // between the two levels: held
    stay(150, 3'b110);
    out_current <= 16'h0064;
    settle(2, 1'b0, 95, 130);
    // relay2 now low current; zero level disables it
    wr(`FCR_OFS_SEL, 32'h0039_0504, `FCR_RESP_OKAY);
    stay(20, 3'b010);
    wr(`FCR_OFS_LDLY, 32'h0000_0005, `FCR_RESP_OKAY);
    wr(`FCR_OFS_LLVL, 32'h0000_00C8, `FCR_RESP_OKAY);
    settle(2, 1'b1, 45, 75);
    out_current <= 16'h012C;
    settle(2, 1'b0, 95, 130);
    // clock enable low freezes detection while frequency rises
    ce <= 1'b0;
    out_freq <= 16'h006F;
    stay(10, 3'b010);
    ce <= 1'b1;
    settle(0, 1'b1, 0, 5);
    final_report();
  end
endmodule
